// ===== hw/auxpc_pkg.sv
// Purpose: constants for the auxiliary pin control block
// Assumes: one 16-bit configuration register reached by index
// Notes:   all field positions, codes and reset values live here
package auxpc_pkg;
  // =========================================================
  // register map
  localparam logic [7:0]  AUX_PIN_CONFIG_IDX = 8'h06;
  localparam logic [15:0] AUX_PIN_CONFIG_RST = 16'h0800;
  localparam logic [15:0] AUX_PIN_CONFIG_WMASK = 16'h3fc0;
  // =========================================================
  // field positions
  localparam int OUT_PAIR_EN_BIT = 13;
  localparam int OPEN_WIRE_BIT   = 12;
  localparam int HOLD_EN_BIT     = 11;
  localparam int FAULT_MODE_HI   = 10;
  localparam int FAULT_MODE_LO   = 9;
  localparam int FAULT_LEVEL_BIT = 8;
  localparam int OUT1_LEVEL_BIT  = 7;
  localparam int OUT0_LEVEL_BIT  = 6;
  // =========================================================
  // fault pin modes
  typedef enum logic [1:0] {
    AUXPC_FAULT_OFF = 2'h0,
    AUXPC_FAULT_IN  = 2'h1,
    AUXPC_FAULT_OD  = 2'h2,
    AUXPC_FAULT_GPO = 2'h3
  } auxpc_fault_mode_t;
endpackage

// ===== hw/auxpc_cfg_if.sv
// Purpose: carries hold configuration from register and sequencer inputs to hold logic
// Assumes: single clock domain
// Notes:   register hold enable and sequencer inputs drive, hold logic reads
`timescale 1ns/10ps
interface auxpc_cfg_if;
  logic hold_en;
  logic alt_hold;
  logic multi_chan;
  modport src (output hold_en, output alt_hold, output multi_chan);
  modport dst (input hold_en, input alt_hold, input multi_chan);
endinterface

// ===== hw/auxpc_hold.sv
// Purpose: conversion-hold logic, immediate and alternate modes
// Assumes: hold pin synchronous to CLK
// Notes:   withheld state clears on pin high
`timescale 1ns/10ps
module auxpc_hold (
  // clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // configuration
  auxpc_cfg_if.dst  cfg,
  // pins and sequencer
  input  wire logic hold_n,
  input  wire logic chan_switch,
  output logic      mod_reset,
  output logic      conv_start
);
  logic withheld_q;
  logic withheld_d;
  logic alt_active;
  logic hold_rise;
  logic hold_q;
  // mode decode
  assign alt_active = cfg.hold_en & cfg.alt_hold & cfg.multi_chan;
  assign hold_rise  = hold_n & ~hold_q;
  // immediate reset only outside alternate mode
  assign mod_reset  = cfg.hold_en & ~cfg.alt_hold & ~hold_n;
  assign withheld_d = alt_active & (withheld_q ? ~hold_n
                                    : (chan_switch & ~hold_n));
  // start next channel when pin releases a withheld conversion
  assign conv_start = withheld_q & hold_n;
  // state
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      withheld_q <= 1'b0;
      hold_q     <= 1'b1;
    end else begin
      withheld_q <= withheld_d;
      hold_q     <= hold_n;
    end
  end
  // assertions
  property p_hold_release;
    @(posedge clk) disable iff (!resetn)
      (withheld_q && hold_n) |-> conv_start ##1 !withheld_q;
  endproperty
  a_hold_release: assert property (p_hold_release)
    else $error("withheld conversion not released");
  property p_withhold;
    @(posedge clk) disable iff (!resetn)
      (alt_active && chan_switch && !hold_n) |=> withheld_q;
  endproperty
  a_withhold: assert property (p_withhold)
    else $error("conversion not withheld at switch");
  property p_imm_reset;
    @(posedge clk) disable iff (!resetn)
      (cfg.hold_en && !cfg.alt_hold && !hold_n) |-> mod_reset;
  endproperty
  a_imm_reset: assert property (p_imm_reset)
    else $error("modulator not held in reset");
  property p_alt_noreset;
    @(posedge clk) disable iff (!resetn) cfg.alt_hold |-> !mod_reset;
  endproperty
  a_alt_noreset: assert property (p_alt_noreset)
    else $error("alternate mode reset modulator");
  c_release: cover property (@(posedge clk) disable iff (!resetn)
    withheld_q ##1 conv_start);
  c_unused: cover property (@(posedge clk) disable iff (!resetn)
    hold_rise);
endmodule

// ===== hw/auxpc_top.sv
// Purpose: auxiliary pin configuration register and pin drivers
// Assumes: register reached by index, 16-bit write strobe and read
// Notes:   fault pin split into input, output and output enable
`timescale 1ns/10ps
module auxpc_top (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RESETN,
  // register access
  input  wire logic [7:0]  REG_INDEX,
  input  wire logic        REG_WRITE,
  input  wire logic [15:0] REG_WDATA,
  output logic      [15:0] REG_RDATA,
  // sequencer and status
  input  wire logic        ALTERNATE_HOLD_SELECT,
  input  wire logic        MULTI_CHANNEL,
  input  wire logic        CHANNEL_SWITCH,
  input  wire logic        STATUS_ERRORS,
  input  wire logic        OTHER_FAULTS,
  output logic             CONVERTER_FAULT,
  output logic             MODULATOR_RESET,
  output logic             CONVERSION_START,
  output logic             OPEN_WIRE_DETECT_ENABLE,
  // pins
  input  wire logic        HOLD_N,
  output logic             GENERAL_OUTPUT_0,
  output logic             GENERAL_OUTPUT_1,
  output logic             GENERAL_OUTPUT_OE,
  input  wire logic        FAULT_PIN_IN,
  output logic             FAULT_PIN_OUT,
  output logic             FAULT_PIN_OE,
  output logic             FAULT_PIN_PULLUP
);
  // =========================================================
  // configuration register
  logic [15:0] cfg_q;
  logic [15:0] cfg_d;
  logic        fault_in_q;
  logic        sel;
  logic [1:0]  fault_mode;
  logic [15:0] rd_view;
  auxpc_cfg_if cfg_bus ();
  assign sel = REG_INDEX == auxpc_pkg::AUX_PIN_CONFIG_IDX;
  // reserved bits never stored
  assign cfg_d = (REG_WRITE && sel)
    ? (REG_WDATA & auxpc_pkg::AUX_PIN_CONFIG_WMASK) : cfg_q;
  assign fault_mode = cfg_q[auxpc_pkg::FAULT_MODE_HI:
                            auxpc_pkg::FAULT_MODE_LO];
  // bit 8 reads pin in input mode
  always_comb begin
    rd_view = cfg_q;
    if (fault_mode == auxpc_pkg::AUXPC_FAULT_IN)
      rd_view[auxpc_pkg::FAULT_LEVEL_BIT] = fault_in_q;
  end
  // register and input sample
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      cfg_q      <= auxpc_pkg::AUX_PIN_CONFIG_RST;
      fault_in_q <= 1'b1;
      REG_RDATA  <= 16'h0000;
    end else begin
      cfg_q      <= cfg_d;
      fault_in_q <= FAULT_PIN_IN;
      REG_RDATA  <= sel ? rd_view : 16'h0000;
    end
  end
  // =========================================================
  // general outputs
  assign GENERAL_OUTPUT_OE = cfg_q[auxpc_pkg::OUT_PAIR_EN_BIT];
  assign GENERAL_OUTPUT_1  = cfg_q[auxpc_pkg::OUT1_LEVEL_BIT];
  assign GENERAL_OUTPUT_0  = cfg_q[auxpc_pkg::OUT0_LEVEL_BIT];
  assign OPEN_WIRE_DETECT_ENABLE = cfg_q[auxpc_pkg::OPEN_WIRE_BIT];
  // =========================================================
  // fault pin
  assign CONVERTER_FAULT = OTHER_FAULTS |
    ((fault_mode == auxpc_pkg::AUXPC_FAULT_IN) & ~fault_in_q);
  // open-drain only pulls low, gpo drives both levels
  assign FAULT_PIN_OUT = (fault_mode == auxpc_pkg::AUXPC_FAULT_GPO)
    & cfg_q[auxpc_pkg::FAULT_LEVEL_BIT];
  assign FAULT_PIN_OE =
    ((fault_mode == auxpc_pkg::AUXPC_FAULT_OD) & STATUS_ERRORS)
    | (fault_mode == auxpc_pkg::AUXPC_FAULT_GPO);
  assign FAULT_PIN_PULLUP = fault_mode == auxpc_pkg::AUXPC_FAULT_GPO;
  // =========================================================
  // hold logic
  assign cfg_bus.hold_en    = cfg_q[auxpc_pkg::HOLD_EN_BIT];
  assign cfg_bus.alt_hold   = ALTERNATE_HOLD_SELECT;
  assign cfg_bus.multi_chan = MULTI_CHANNEL;
  auxpc_hold u_hold (
    .clk         (CLK),
    .resetn      (RESETN),
    .cfg         (cfg_bus),
    .hold_n      (HOLD_N),
    .chan_switch (CHANNEL_SWITCH),
    .mod_reset   (MODULATOR_RESET),
    .conv_start  (CONVERSION_START)
  );
  // =========================================================
  // assertions
  // a write that clears the pair enable must switch both outputs off
  property p_gpo_off;
    @(posedge CLK) disable iff (!RESETN)
      (REG_WRITE && sel && !REG_WDATA[auxpc_pkg::OUT_PAIR_EN_BIT]) |=>
        !GENERAL_OUTPUT_OE;
  endproperty
  a_gpo_off: assert property (p_gpo_off)
    else $error("outputs driven while disabled");
  property p_wr_out1;
    @(posedge CLK) disable iff (!RESETN)
      (REG_WRITE && sel) |=> GENERAL_OUTPUT_1 ==
        $past(REG_WDATA[auxpc_pkg::OUT1_LEVEL_BIT]);
  endproperty
  a_wr_out1: assert property (p_wr_out1)
    else $error("output 1 level wrong");
  property p_wr_out0;
    @(posedge CLK) disable iff (!RESETN)
      (REG_WRITE && sel) |=> GENERAL_OUTPUT_0 ==
        $past(REG_WDATA[auxpc_pkg::OUT0_LEVEL_BIT]);
  endproperty
  a_wr_out0: assert property (p_wr_out0)
    else $error("output 0 level wrong");
  property p_ow;
    @(posedge CLK) disable iff (!RESETN)
      (REG_WRITE && sel) |=> OPEN_WIRE_DETECT_ENABLE ==
        $past(REG_WDATA[auxpc_pkg::OPEN_WIRE_BIT]);
  endproperty
  a_ow: assert property (p_ow)
    else $error("open wire enable wrong");
  property p_off_mode;
    @(posedge CLK) disable iff (!RESETN)
      fault_mode == auxpc_pkg::AUXPC_FAULT_OFF |-> !FAULT_PIN_OE;
  endproperty
  a_off_mode: assert property (p_off_mode)
    else $error("disabled fault pin driven");
  property p_od;
    @(posedge CLK) disable iff (!RESETN)
      fault_mode == auxpc_pkg::AUXPC_FAULT_OD |->
        FAULT_PIN_OE == STATUS_ERRORS && !FAULT_PIN_OUT;
  endproperty
  a_od: assert property (p_od)
    else $error("open-drain fault wrong");
  property p_in;
    @(posedge CLK) disable iff (!RESETN)
      (fault_mode == auxpc_pkg::AUXPC_FAULT_IN && !FAULT_PIN_IN) |=>
        CONVERTER_FAULT || fault_mode != auxpc_pkg::AUXPC_FAULT_IN;
  endproperty
  a_in: assert property (p_in)
    else $error("fault input lost");
  property p_rd_resv;
    @(posedge CLK) disable iff (!RESETN)
      (REG_RDATA & ~auxpc_pkg::AUX_PIN_CONFIG_WMASK) == 16'h0000;
  endproperty
  a_rd_resv: assert property (p_rd_resv)
    else $error("reserved bits nonzero");
  property p_gpo_fault;
    @(posedge CLK) disable iff (!RESETN)
      fault_mode == auxpc_pkg::AUXPC_FAULT_GPO |->
        FAULT_PIN_OE && FAULT_PIN_OUT == cfg_q[auxpc_pkg::FAULT_LEVEL_BIT];
  endproperty
  a_gpo_fault: assert property (p_gpo_fault)
    else $error("fault gpo level wrong");
  c_od: cover property (@(posedge CLK) disable iff (!RESETN)
    FAULT_PIN_OE && !FAULT_PIN_OUT);
  c_gpo: cover property (@(posedge CLK) disable iff (!RESETN)
    GENERAL_OUTPUT_OE && GENERAL_OUTPUT_1);
  c_in: cover property (@(posedge CLK) disable iff (!RESETN)
    CONVERTER_FAULT && !OTHER_FAULTS);
endmodule

// ===== testbench/auxpc_ext_model.sv
// Purpose: far side of the fault pin, a shared line with a pull-up
// Assumes: other devices on the line may pull it low at any time
// Notes:   the resolved level feeds the design's pin input
`timescale 1ns/10ps
module auxpc_ext_model (
  // design side of the pin
  input  wire logic pin_out,
  input  wire logic pin_oe,
  // other devices on the line
  input  wire logic other_low,
  // resolved wire level
  output logic      pin_level
);
  // ==========================================================
  // wired line: the pull-up wins unless somebody drives low
  assign pin_level = pin_oe ? (pin_out & !other_low)
                            : !other_low;
endmodule

// ===== testbench/test_aux_pin_control.sv
// Purpose: register and pin checks for the auxiliary pin block
// Assumes: register reached by index with a one-cycle write strobe
// Notes:   fault line resolved by the external model
`timescale 1ns/10ps
module test_aux_pin_control;
  logic        clk = 1'b0, resetn = 1'b0, wr_en = 1'b0, alt = 1'b0;
  logic        multi = 1'b0, sw = 1'b0, serr = 1'b0, oth = 1'b0;
  logic        hold_n = 1'b1, ext_low = 1'b0;
  logic [7:0]  idx = 8'h06;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata;
  logic        cfault, mreset, cstart, owd, go0, go1, goe;
  logic        fin, fout, foe, fpu;
  logic [15:0] wv [4] = '{16'h2080, 16'h2040, 16'h00c0, 16'h1000};
  logic [15:0] we [4] = '{16'hc, 16'ha, 16'h6, 16'h1};
  int          fails = 0;
  int          tests_run = 0;
  // ==========================================================
  // design and far side
  auxpc_top uut (
    .CLK(clk), .RESETN(resetn), .REG_INDEX(idx), .REG_WRITE(wr_en),
    .REG_WDATA(wdata), .REG_RDATA(rdata), .ALTERNATE_HOLD_SELECT(alt),
    .MULTI_CHANNEL(multi), .CHANNEL_SWITCH(sw), .STATUS_ERRORS(serr),
    .OTHER_FAULTS(oth), .CONVERTER_FAULT(cfault), .MODULATOR_RESET(mreset),
    .CONVERSION_START(cstart), .OPEN_WIRE_DETECT_ENABLE(owd),
    .HOLD_N(hold_n), .GENERAL_OUTPUT_0(go0), .GENERAL_OUTPUT_1(go1),
    .GENERAL_OUTPUT_OE(goe), .FAULT_PIN_IN(fin), .FAULT_PIN_OUT(fout),
    .FAULT_PIN_OE(foe), .FAULT_PIN_PULLUP(fpu));
  auxpc_ext_model ext (.pin_out(fout), .pin_oe(foe), .other_low(ext_low),
    .pin_level(fin));
  // ==========================================================
  // helpers
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one write strobe, pins settled on return
  task wr(input logic [7:0] i, input logic [15:0] d);
    @(posedge clk);
    idx <= i;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    idx <= 8'h06;
    #1;
  endtask
  // read data lags the index by one cycle
  task rd(input logic [7:0] i, input logic [15:0] e);
    @(posedge clk);
    idx <= i;
    tick(2);
    chk(rdata, e);
  endtask
  task end_sim;
    if (fails == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ==========================================================
  // clock and watchdog
  initial forever #4 clk = ~clk;
  initial begin
    repeat (2000) @(posedge clk);
    fails++;
    end_sim();
  end
  // ==========================================================
  // test sequence
  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    tick(1);
    chk(16'({goe, owd, foe}), 16'h0);
    rd(8'h06, 16'h0800);
    wr(8'h06, 16'hffff);
    chk(16'({goe, go1, go0, owd, foe, fout, fpu}), 16'h7f);
    rd(8'h06, 16'h3fc0);
    wr(8'h07, 16'h0000);
    rd(8'h06, 16'h3fc0);
    rd(8'h07, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      wr(8'h06, wv[i]);
      chk(16'({goe, go1, go0, owd}), we[i]);
    end
    // fault pin as general output driven low
    wr(8'h06, 16'h0600);
    chk(16'({foe, fout, fin, fpu}), 16'h9);
    // fault pin as input, pulled low by another device
    @(posedge clk);
    ext_low <= 1'b1;
    wr(8'h06, 16'h0b00);
    tick(2);
    chk(16'(cfault), 16'h1);
    rd(8'h06, 16'h0a00);
    @(posedge clk);
    ext_low <= 1'b0;
    tick(2);
    chk(16'(cfault), 16'h0);
    rd(8'h06, 16'h0b00);
    @(posedge clk);
    oth <= 1'b1;
    tick(1);
    chk(16'(cfault), 16'h1);
    // fault pin as open-drain error output
    wr(8'h06, 16'h0c00);
    chk(16'({foe, fin}), 16'h1);
    @(posedge clk);
    serr <= 1'b1;
    tick(1);
    chk(16'({foe, fout, fin}), 16'h4);
    // immediate hold
    @(posedge clk);
    serr <= 1'b0;
    hold_n <= 1'b0;
    tick(1);
    chk(16'(mreset), 16'h1);
    @(posedge clk);
    hold_n <= 1'b1;
    tick(1);
    chk(16'(mreset), 16'h0);
    // alternate hold across a channel switch
    @(posedge clk);
    alt <= 1'b1;
    multi <= 1'b1;
    hold_n <= 1'b0;
    sw <= 1'b1;
    @(posedge clk);
    sw <= 1'b0;
    tick(2);
    chk(16'({mreset, cstart}), 16'h0);
    @(posedge clk);
    hold_n <= 1'b1;
    #1;
    chk(16'(cstart), 16'h1);
    tick(1);
    chk(16'(cstart), 16'h0);
    end_sim();
  end
endmodule
